// ---- design/sewc_top.sv ----
// Write-state control for a serial byte-addressed nonvolatile memory.
// Assumes rstn_i is the internal power-on reset; pins are asynchronous.
// Functional notes
// - Leaving power-on reset, enter standby, never an active or writing state.
// - Power-on reset reassertion drops to reset mode, abandoning current state.
// - Out of reset the write-enable latch is clear and standby holds.
// - Host selects first; device becomes ready only after chip select low.
// - Completed byte, page or status write clears the write-enable latch.
// - Programming begins on chip select rising after the correct bit count.
// - Array access during programming is ignored; programming runs to the end.
// - Unknown instruction: no action, serial output stays high impedance.
// - Write-enable command sets latch and status flag when select rises.
// - Write-disable command clears the write-enable latch.
// - During programming only the status read command is honoured.
// - Busy flag high during programming, low when ready.
`timescale 1ns/1ps
`default_nettype none
`include "sewc_cfg.svh"
module sewc_top #(
  parameter int PROG_CYCLES = `SEWC_PROG_CYCLES
) (
  // Clock and power-on reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Serial link pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // State view
  output logic write_enable_latch_o,
  output logic busy_o,
  output logic ready_o,
  output logic prog_start_o
);
  logic cs_q;
  logic sck_q;
  logic si_q;
  logic sck_d_r;
  logic cs_d_r;
  logic [8:0] bits_r;
  logic [7:0] op_r;
  logic [7:0] sr_sh_r;
  logic [15:0] pcnt_r;
  logic write_enable_latch_r;
  logic [7:0] sr_now;
  logic is_write;
  sewc_pkg::sewc_mode_e mode_r;

  sewc_sync u_cs (.clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(cs_n_i), .init_i(1'b1),
    .lvl_o(cs_q));
  sewc_sync u_sck (.clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(sck_i), .init_i(1'b1),
    .lvl_o(sck_q));
  sewc_sync u_si (.clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_i(si_i), .init_i(1'b1),
    .lvl_o(si_q));

  wire sck_rise = sck_q & ~sck_d_r;
  wire sck_fall = ~sck_q & sck_d_r;
  wire cs_rise = cs_q & ~cs_d_r;
  wire sel = ~cs_q;
  wire prog = (mode_r == sewc_pkg::SEWC_PROG);
  wire op_done = (bits_r == 9'h008);
  wire [7:0] op_now = op_r;
  wire wr_arr = (op_now == `SEWC_OP_WRITE) && (bits_r >= 9'(`SEWC_WR_MIN_BITS))
    && (bits_r[2:0] == 3'h0) && (bits_r <= 9'(`SEWC_WR_MAX_BITS));
  wire wr_sr = (op_now == `SEWC_OP_STATUS_WR) && (bits_r == 9'(`SEWC_WSR_BITS));
  assign is_write = write_enable_latch_r && (wr_arr || wr_sr);
  wire pdone = prog && (pcnt_r == 16'h0001);

  // Status byte as seen by the host: latch and busy flag, rest zero
  always_comb
  begin
    sr_now = 8'h00;
    sr_now[`SEWC_SR_LATCH_BIT] = write_enable_latch_r;
    sr_now[`SEWC_SR_BUSY_BIT] = prog;
  end

  // Edge history of synchronised pins
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sck_d_r <= 1'b1; // Matches the synchroniser's reset level, no false rise
      cs_d_r <= 1'b1;
    end
    else
    begin
      sck_d_r <= sck_q;
      cs_d_r <= cs_q;
    end
  end

  // Bit counter and opcode shift; frame restarts on deselect
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bits_r <= 9'h000;
      op_r <= 8'h00;
    end
    else if (!sel)
      bits_r <= 9'h000;
    else if (sck_rise)
    begin
      if (bits_r < 9'h008)
        op_r <= {op_r[6:0], si_q};
      if (bits_r != 9'h1FF)
        bits_r <= bits_r + 9'h001; // saturates, long frames never wrap to legal
    end
  end

  // Mode: standby after reset, ready once selected, programming after write
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mode_r <= sewc_pkg::SEWC_RESET;
    else
    begin
      unique case (mode_r)
        sewc_pkg::SEWC_RESET: mode_r <= sewc_pkg::SEWC_STANDBY;
        sewc_pkg::SEWC_STANDBY: if (sel) mode_r <= sewc_pkg::SEWC_READY;
        sewc_pkg::SEWC_READY:
          if (cs_rise)
            mode_r <= is_write ? sewc_pkg::SEWC_PROG : sewc_pkg::SEWC_STANDBY;
        sewc_pkg::SEWC_PROG: if (pdone) mode_r <= sewc_pkg::SEWC_STANDBY;
      endcase
    end
  end

  // Programming timer runs to the end whatever the pins do
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pcnt_r <= 16'h0000;
    else if (mode_r == sewc_pkg::SEWC_READY && cs_rise && is_write)
      pcnt_r <= 16'(PROG_CYCLES);
    else if (prog && pcnt_r != 16'h0000)
      pcnt_r <= pcnt_r - 16'h0001;
  end

  // Write-enable latch; clears after programming, commands ignored while busy
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      write_enable_latch_r <= 1'b0;
    else if (pdone)
      write_enable_latch_r <= 1'b0;
    else if (!prog && mode_r == sewc_pkg::SEWC_READY && cs_rise && op_done)
    begin
      if (op_now == `SEWC_OP_WRITE_ENABLE)
        write_enable_latch_r <= 1'b1;
      else if (op_now == `SEWC_OP_WRITE_DISABLE)
        write_enable_latch_r <= 1'b0;
    end
  end

  // Status read: drive on falling clock after opcode, only for known reads
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      so_oe_o <= 1'b0;
      so_o <= 1'b0;
      sr_sh_r <= 8'h00;
    end
    else if (!sel)
      so_oe_o <= 1'b0;
    else if (sck_fall && bits_r >= 9'h008 && op_now == `SEWC_OP_STATUS_RD)
    begin
      if (bits_r[2:0] == 3'h0)
      begin
        so_o <= sr_now[7]; // MSB must already stand at the first data rise
        sr_sh_r <= {sr_now[6:0], 1'b0};
      end
      else
      begin
        so_o <= sr_sh_r[7];
        sr_sh_r <= {sr_sh_r[6:0], 1'b0};
      end
      so_oe_o <= 1'b1;
    end
    else if (sck_fall && op_now != `SEWC_OP_STATUS_RD)
      so_oe_o <= 1'b0;
  end

  // Registered state view
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      write_enable_latch_o <= 1'b0;
      busy_o <= 1'b0;
      ready_o <= 1'b0;
      prog_start_o <= 1'b0;
    end
    else
    begin
      write_enable_latch_o <= write_enable_latch_r;
      busy_o <= prog;
      ready_o <= (mode_r == sewc_pkg::SEWC_READY);
      prog_start_o <= (mode_r == sewc_pkg::SEWC_READY) && cs_rise && is_write;
    end
  end

  AST_RESET_STANDBY: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    mode_r == sewc_pkg::SEWC_RESET |=> mode_r == sewc_pkg::SEWC_STANDBY)
    else $error("reset did not lead to standby");
  AST_NO_LATCH_OUT_RESET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    mode_r == sewc_pkg::SEWC_RESET |-> !write_enable_latch_r)
    else $error("latch set at reset exit");
  AST_PROG_NEEDS_LATCH: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(prog) |-> $past(write_enable_latch_r))
    else $error("programming without write enable");
  AST_READY_NEEDS_SEL: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(mode_r == sewc_pkg::SEWC_READY) |-> $past(sel))
    else $error("ready without select");
  AST_LATCH_CLEARS: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pdone |=> !write_enable_latch_r && mode_r == sewc_pkg::SEWC_STANDBY)
    else $error("latch not cleared after write");
  AST_PROG_ON_CS: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(prog) |-> $past(cs_rise))
    else $error("programming began without select rise");
  AST_PROG_HOLDS: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(prog) |-> prog [*8])
    else $error("programming cut short");
  AST_BAD_OP_QUIET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    so_oe_o |-> op_r == `SEWC_OP_STATUS_RD)
    else $error("output driven for other opcode");
  AST_LATCH_STABLE_PROG: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    prog && !pdone |=> $stable(write_enable_latch_r))
    else $error("latch changed during programming");
  AST_BUSY_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ##1 busy_o == $past(prog))
    else $error("busy flag wrong");
  AST_NO_SHORT_PROG: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    cs_rise && !is_write |=> !prog || $past(prog))
    else $error("programming from bad count");
  AST_LATCH_SET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(write_enable_latch_r) |-> $past(cs_rise && op_r == `SEWC_OP_WRITE_ENABLE))
    else $error("latch set without command");

  COV_WRITE_ENABLE: cover property (@(posedge ref_clk_i) $rose(write_enable_latch_r));
  COV_PROG: cover property (@(posedge ref_clk_i) $rose(prog));
  COV_DONE: cover property (@(posedge ref_clk_i) pdone);
  COV_SR_READ: cover property (@(posedge ref_clk_i) so_oe_o && prog);
endmodule
`default_nettype wire

// ---- design/sewc_cfg.svh ----
// Constants for the serial nonvolatile write-state control block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef SEWC_CFG_SVH
`define SEWC_CFG_SVH
`define SEWC_OP_WRITE_ENABLE 8'h06
`define SEWC_OP_WRITE_DISABLE 8'h04
`define SEWC_OP_STATUS_RD 8'h05
`define SEWC_OP_STATUS_WR 8'h01
`define SEWC_OP_READ 8'h03
`define SEWC_OP_WRITE 8'h02
`define SEWC_SR_BUSY_BIT 0
`define SEWC_SR_LATCH_BIT 1
`define SEWC_WSR_BITS 16
`define SEWC_WR_MIN_BITS 32
`define SEWC_WR_MAX_BITS 288
`define SEWC_PROG_TIME_US 5
`define SEWC_CLK_MHZ 100
`define SEWC_PROG_CYCLES (`SEWC_PROG_TIME_US * `SEWC_CLK_MHZ)
`endif

// ---- design/sewc_pkg.sv ----
// Types for the serial nonvolatile write-state control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sewc_pkg;
  typedef enum logic [1:0] {SEWC_RESET, SEWC_STANDBY, SEWC_READY, SEWC_PROG} sewc_mode_e;
endpackage

// ---- design/sewc_sync.sv ----
// Three-stage synchroniser with agree-filter for one pin input.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module sewc_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pin and filtered level
  input wire logic pin_i,
  input wire logic init_i,
  output logic lvl_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Chain; the first stage feeds only the second
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level only moves when the two later stages agree
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      lvl_o <= 1'b1;
    else if (s2_r == s3_r)
      lvl_o <= s3_r;
  end

  logic unused_init;
  assign unused_init = init_i;
endmodule
`default_nettype wire

// ---- tb/sewc_host.sv ----
// Serial host model driving select, clock and data of the block.
// Assumes clk_i is the 100 MHz bench clock; pins move on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module sewc_host (
  // Bench clock
  input wire logic clk_i,
  // Serial pins
  input wire logic so_i,
  output var logic cs_n_o,
  output var logic sck_o,
  output var logic si_o
);
  // Idle: deselected, clock parked low
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // Mode 0 frame, MSB first; bits of 120 and 130 ns alternate, 125 ns on average
  task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk_i);
    cs_n_o <= 1'b0;
    repeat (6) @(negedge clk_i);
    for (int k = n - 1; k >= 0; k--)
    begin
      si_o <= d[k];
      repeat (6) @(negedge clk_i);
      sck_o <= 1'b1;
      repeat (6 + (k % 2)) @(negedge clk_i);
      rd = {rd[6:0], so_i};
      sck_o <= 1'b0;
    end
    repeat (6) @(negedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o; // Released line must not hold its last bit
    repeat (20) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the write-state control block.
// Assumes the host model and design sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sewc_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  // Long enough that two frames fit inside one programming cycle
  localparam int PROG = 2000;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  wire cs_n, sck, si, so, so_oe, latch, busy, ready, start;
  tri1 so_w;
  int error_cnt = 0;
  int comparisons = 0;
  int starts = 0;
  logic oe_hit = 1'b0;
  logic rdy_hit = 1'b0;
  logic [7:0] rd;
  // Pull-up on the serial output when undriven
  assign so_w = so_oe ? so : 1'bz;
  always #5 ref_clk_i = ~ref_clk_i;
  // Event watchers
  always @(posedge ref_clk_i)
  begin
    if (start)
      starts++;
    if (so_oe)
      oe_hit = 1'b1;
    if (!cs_n && ready)
      rdy_hit = 1'b1;
  end
  sewc_top #(.PROG_CYCLES(PROG)) i_sewc_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .write_enable_latch_o(latch), .busy_o(busy), .ready_o(ready), .prog_start_o(start));
  sewc_host i_sewc_host (.clk_i(ref_clk_i), .so_i(so_w), .cs_n_o(cs_n), .sck_o(sck),
    .si_o(si));
  task automatic send(input logic [31:0] d, input int n);
    i_sewc_host.frame(d, n, rd);
  endtask
  // Bounded wait for the end of programming
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    `CHK({latch, busy, ready}, 3'b000)
    send({8'h02, 16'h0010, 8'hA5}, 32);
    `CHK(starts, 0)
    `CHK(rdy_hit, 1'b1)
    send(`SEWC_OP_WRITE_ENABLE, 8);
    `CHK(latch, 1'b1)
    send(`SEWC_OP_WRITE_DISABLE, 8);
    `CHK(latch, 1'b0)
    send(`SEWC_OP_WRITE_ENABLE, 8);
    i_sewc_host.frame({`SEWC_OP_STATUS_RD, 8'h00}, 16, rd);
    `CHK(rd, 8'h02)
    send({8'h02, 16'h0010}, 24);
    `CHK({starts, latch}, {32'd0, 1'b1})
    send({8'h02, 16'h0010, 8'hA5}, 32);
    `CHK({starts, busy}, {32'd1, 1'b1})
    i_sewc_host.frame({`SEWC_OP_STATUS_RD, 8'h00}, 16, rd);
    `CHK(rd, 8'h03)
    send(`SEWC_OP_WRITE_DISABLE, 8);
    `CHK(latch, 1'b1)
    send({8'h02, 16'h0020, 8'h5A}, 32);
    wait_idle();
    `CHK({starts, busy, latch}, {32'd1, 2'b00})
    send(`SEWC_OP_WRITE_ENABLE, 8);
    send({8'h01, 8'h00}, 16);
    `CHK(starts, 2)
    wait_idle();
    `CHK(latch, 1'b0)
    oe_hit = 1'b0;
    send({8'hFF, 8'h00}, 16);
    `CHK({oe_hit, latch, starts}, {2'b00, 32'd2})
    send(`SEWC_OP_WRITE_ENABLE, 8);
    send({8'h02, 16'h0030, 8'h11}, 32);
    rstn_i = 1'b0;
    @(negedge ref_clk_i);
    `CHK({latch, busy, ready}, 3'b000)
    rstn_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    `CHK({latch, busy, ready}, 3'b000)
    end_of_test();
  end
  // Watchdog, about seven times the expected run
  initial
  begin
    #500000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
